// file: nfc_irq_map.vh
`ifndef NFC_IRQ_MAP_VH
`define NFC_IRQ_MAP_VH

// register indices; byte address is four times the index
`define IDX_MAIN_MASK 6'h16
`define IDX_TMR_MASK 6'h17
`define IDX_ERR_MASK 6'h18
`define IDX_TGT_MASK 6'h19
`define IDX_MAIN_FLAGS 6'h1a
`define IDX_TMR_FLAGS 6'h1b
`define IDX_ERR_FLAGS 6'h1c
`define IDX_TGT_FLAGS 6'h1d

// writable and implemented bits
`define MAIN_MASK_WMASK 8'hfe
`define TMR_MASK_WMASK 8'hff
`define ERR_MASK_WMASK 8'hff
`define TGT_MASK_WMASK 8'h7b
`define MAIN_FLAG_BITS 8'hfe
`define TMR_FLAG_BITS 8'hff
`define ERR_FLAG_BITS 8'hff
`define TGT_FLAG_BITS 8'h7b
`define MASK_RESET 8'h00
`define FLAG_RESET 8'h00

// fifo water level thresholds
`define FIFO_RX_LEVEL 10'h12c
`define FIFO_TX_LEVEL 10'h0c8

// minimum guard time after own field on
`define GUARD_TIME_NS 75000
`define CLK_PERIOD_NS 8

// ahb-lite encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HADDR_HIGH_ZERO 24'h000000
`define RDATA_ZERO 32'h00000000

`endif

// file: irq_flag_reg.v
`timescale 1ns/10ps
`default_nettype none
`include "nfc_irq_map.vh"

module irq_flag_reg #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] BITS = {WIDTH{1'b1}}
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] set,
   input wire clr,
   output wire [WIDTH-1:0] flags
);
   reg [WIDTH-1:0] flags_reg;
   wire [WIDTH-1:0] flags_next;

   // a set in the clearing cycle survives the read clear
   assign flags_next = ((clr ? {WIDTH{1'b0}} : flags_reg) | set) & BITS;
   assign flags = flags_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= {WIDTH{1'b0}};
      end else begin
         flags_reg <= flags_next;
      end
   end
endmodule
`default_nettype wire

// file: fifo_level_detect.v
`timescale 1ns/10ps
`default_nettype none
`include "nfc_irq_map.vh"

module fifo_level_detect #(
   parameter CW = 10
) (
   input wire clk,
   input wire rst_n,
   input wire [CW-1:0] count,
   input wire rx_active,
   input wire tx_active,
   output reg level_set
);
   reg cond_reg;
   wire cond;

   // fires on entry so a cleared flag is not re-raised every cycle
   assign cond = (rx_active && (count > `FIFO_RX_LEVEL)) ||
                 (tx_active && (count < `FIFO_TX_LEVEL));

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_reg <= 1'b0;
         level_set <= 1'b0;
      end else begin
         cond_reg <= cond;
         level_set <= cond && !cond_reg;
      end
   end
endmodule
`default_nettype wire

// file: nfc_irq_flags_and_masks.v
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "nfc_irq_map.vh"

module nfc_irq_flags_and_masks #(
   parameter GUARD_CYCLES = (`GUARD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter GW = 16,
   parameter MW = 8
) (
   input wire CLK_SYS,
   input wire RST_N,
   // ahb-lite slave
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   // asynchronous analog levels
   input wire OSC_EN,
   input wire OSC_STABLE,
   input wire EXT_FIELD,
   // main event pulses
   input wire RX_START,
   input wire RX_END,
   input wire TX_END,
   input wire BIT_COLLISION,
   input wire DISTURBANCE_FRAME,
   input wire [9:0] FIFO_COUNT,
   input wire RX_ACTIVE,
   input wire TX_ACTIVE,
   // timer and field event pulses
   input wire DCT_DONE,
   input wire NRT_EXPIRE,
   input wire GPT_EXPIRE,
   input wire CA_COLLISION,
   input wire CA_NO_FIELD,
   input wire FIELD_OFF_REQ,
   input wire TARGET_MODE,
   input wire BITRATE_FOUND,
   // error and wake-up sources
   input wire [4:0] ERR_EVENTS,
   input wire [2:0] MEAS_DONE,
   input wire [3*MW-1:0] MEAS_DELTA,
   input wire [3*MW-1:0] MEAS_REF,
   // passive target event pulses
   input wire [7:0] TGT_EVENTS,
   output reg FIELD_ON,
   output reg IRQ
);
   localparam ST_IDLE = 2'b01;
   localparam ST_GUARD = 2'b10;

   // synchronisers for analog levels
   reg osc_s1_reg;
   reg osc_s2_reg;
   reg osc_prev_reg;
   reg fld_s1_reg;
   reg fld_s2_reg;
   reg fld_prev_reg;
   reg en_s1_reg;
   reg en_s2_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
         fld_s1_reg <= 1'b0;
         fld_s2_reg <= 1'b0;
         fld_prev_reg <= 1'b0;
         en_s1_reg <= 1'b0;
         en_s2_reg <= 1'b0;
      end else begin
         osc_s1_reg <= OSC_STABLE;
         osc_s2_reg <= osc_s1_reg;
         osc_prev_reg <= osc_s2_reg;
         fld_s1_reg <= EXT_FIELD;
         fld_s2_reg <= fld_s1_reg;
         fld_prev_reg <= fld_s2_reg;
         en_s1_reg <= OSC_EN;
         en_s2_reg <= en_s1_reg;
      end
   end

   wire osc_set;
   wire eon_set;
   wire eof_set;
   assign osc_set = en_s2_reg && osc_s2_reg && !osc_prev_reg;
   assign eon_set = fld_s2_reg && !fld_prev_reg;
   assign eof_set = !fld_s2_reg && fld_prev_reg;

   wire wl_set;
   fifo_level_detect #(
      .CW(10)
   ) u_fifo_level (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .count(FIFO_COUNT),
      .rx_active(RX_ACTIVE),
      .tx_active(TX_ACTIVE),
      .level_set(wl_set)
   );

   // collision avoidance: own field on, then the minimum guard time
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [GW-1:0] guard_cnt_reg;
   reg [GW-1:0] guard_cnt_next;
   reg field_on_next;
   reg cat_set;

   always @* begin
      state_next = state_reg;
      guard_cnt_next = guard_cnt_reg;
      field_on_next = FIELD_ON;
      cat_set = 1'b0;
      if (FIELD_OFF_REQ) begin
         field_on_next = 1'b0;
      end
      case (state_reg)
         ST_IDLE: begin
            if (CA_NO_FIELD) begin
               field_on_next = 1'b1;
               guard_cnt_next = {GW{1'b0}};
               state_next = ST_GUARD;
            end
         end
         ST_GUARD: begin
            field_on_next = 1'b1;
            if (guard_cnt_reg == GUARD_CYCLES[GW-1:0] - 1'b1) begin
               cat_set = 1'b1;
               state_next = ST_IDLE;
            end else begin
               guard_cnt_next = guard_cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= ST_IDLE;
         guard_cnt_reg <= {GW{1'b0}};
         FIELD_ON <= 1'b0;
      end else begin
         state_reg <= state_next;
         guard_cnt_reg <= guard_cnt_next;
         FIELD_ON <= field_on_next;
      end
   end

   // wake-up measurement comparators
   wire [2:0] wake_set;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_wake
         assign wake_set[gi] = MEAS_DONE[gi] &&
            (MEAS_DELTA[gi*MW +: MW] > MEAS_REF[gi*MW +: MW]);
      end
   endgenerate

   // ahb-lite address phase capture
   reg wr_pend_reg;
   reg [5:0] wr_idx_reg;
   wire addr_ok;
   wire rd_take;
   wire wr_take;
   wire [5:0] idx;

   // only whole-word transfers are meaningful; narrower ones still hit the word
   assign idx = HADDR[7:2];
   assign addr_ok = (HADDR[31:8] == `HADDR_HIGH_ZERO);
   assign rd_take = HSEL && HREADY && HTRANS[1] && !HWRITE;
   assign wr_take = HSEL && HREADY && HTRANS[1] && HWRITE && addr_ok;

   // masks
   reg [7:0] main_mask_reg;
   reg [7:0] tmr_mask_reg;
   reg [7:0] err_mask_reg;
   reg [7:0] tgt_mask_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 6'h00;
         main_mask_reg <= `MASK_RESET;
         tmr_mask_reg <= `MASK_RESET;
         err_mask_reg <= `MASK_RESET;
         tgt_mask_reg <= `MASK_RESET;
      end else begin
         wr_pend_reg <= wr_take;
         wr_idx_reg <= idx;
         if (wr_pend_reg) begin
            case (wr_idx_reg)
               `IDX_MAIN_MASK: main_mask_reg <= HWDATA[7:0] & `MAIN_MASK_WMASK;
               `IDX_TMR_MASK: tmr_mask_reg <= HWDATA[7:0] & `TMR_MASK_WMASK;
               `IDX_ERR_MASK: err_mask_reg <= HWDATA[7:0] & `ERR_MASK_WMASK;
               `IDX_TGT_MASK: tgt_mask_reg <= HWDATA[7:0] & `TGT_MASK_WMASK;
               // flag registers ignore writes
               default: begin
               end
            endcase
         end
      end
   end

   // read of a flag register clears it at the edge that captures the data
   wire clr_main;
   wire clr_tmr;
   wire clr_err;
   wire clr_tgt;
   assign clr_main = rd_take && addr_ok && (idx == `IDX_MAIN_FLAGS);
   assign clr_tmr = rd_take && addr_ok && (idx == `IDX_TMR_FLAGS);
   assign clr_err = rd_take && addr_ok && (idx == `IDX_ERR_FLAGS);
   assign clr_tgt = rd_take && addr_ok && (idx == `IDX_TGT_FLAGS);

   wire [7:0] main_set;
   wire [7:0] tmr_set;
   wire [7:0] err_set;
   wire [7:0] main_flags;
   wire [7:0] tmr_flags;
   wire [7:0] err_flags;
   wire [7:0] tgt_flags;

   assign main_set = {osc_set, wl_set, RX_START, RX_END, TX_END,
                      BIT_COLLISION, DISTURBANCE_FRAME, 1'b0};
   assign tmr_set = {DCT_DONE, NRT_EXPIRE, GPT_EXPIRE, eon_set, eof_set,
                     CA_COLLISION, cat_set, TARGET_MODE && BITRATE_FOUND};
   assign err_set = {ERR_EVENTS, wake_set};

   irq_flag_reg #(
      .WIDTH(8),
      .BITS(`MAIN_FLAG_BITS)
   ) u_main_flags (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .set(main_set),
      .clr(clr_main),
      .flags(main_flags)
   );

   // the clash flag is cleared by the host reading this register first
   irq_flag_reg #(
      .WIDTH(8),
      .BITS(`TMR_FLAG_BITS)
   ) u_tmr_flags (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .set(tmr_set),
      .clr(clr_tmr),
      .flags(tmr_flags)
   );

   irq_flag_reg #(
      .WIDTH(8),
      .BITS(`ERR_FLAG_BITS)
   ) u_err_flags (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .set(err_set),
      .clr(clr_err),
      .flags(err_flags)
   );

   irq_flag_reg #(
      .WIDTH(8),
      .BITS(`TGT_FLAG_BITS)
   ) u_tgt_flags (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .set(TGT_EVENTS),
      .clr(clr_tgt),
      .flags(tgt_flags)
   );

   // read mux, registered so hrdata stands through the data phase
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (addr_ok) begin
         case (idx)
            `IDX_MAIN_MASK: rd_byte = main_mask_reg;
            `IDX_TMR_MASK: rd_byte = tmr_mask_reg;
            `IDX_ERR_MASK: rd_byte = err_mask_reg;
            `IDX_TGT_MASK: rd_byte = tgt_mask_reg;
            `IDX_MAIN_FLAGS: rd_byte = main_flags;
            `IDX_TMR_FLAGS: rd_byte = tmr_flags;
            `IDX_ERR_FLAGS: rd_byte = err_flags;
            `IDX_TGT_FLAGS: rd_byte = tgt_flags;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   wire irq_next;
   assign irq_next = |(main_flags & ~main_mask_reg) |
                     |(tmr_flags & ~tmr_mask_reg) |
                     |(err_flags & ~err_mask_reg) |
                     |(tgt_flags & ~tgt_mask_reg);

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         HRDATA <= `RDATA_ZERO;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         // zero wait states, always okay
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         IRQ <= irq_next;
         if (rd_take) begin
            HRDATA <= {24'h000000, rd_byte};
         end
      end
   end
endmodule
`default_nettype wire

// file: host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   output logic HSEL,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA
);
   initial begin
      HSEL = 1'h0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'h0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
   end
   // single word transfer; waits on hready, never on a fixed count
   task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      HSEL <= 1'h1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, i, 2'h0};
      HWRITE <= w;
      @(posedge clk);
      while (!HREADY) @(posedge clk);
      HTRANS <= 2'h0;
      HWDATA <= d;
      @(posedge clk);
      while (!HREADY) @(posedge clk);
      q = HRDATA;
      HSEL <= 1'h0;
   endtask
endmodule
`default_nettype wire

// file: nfc_irq_chk.sv
`timescale 1ns/10ps
`default_nettype none
module nfc_irq_chk (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic CA_NO_FIELD,
   input wire logic FIELD_OFF_REQ,
   input wire logic FIELD_ON,
   input wire logic IRQ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire acc = HSEL && HREADY && HTRANS[1];
   logic [2:0] acc_q;
   // irq may only drop up to three edges after a bus access
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) acc_q <= 3'h0;
      else acc_q <= {acc_q[1:0], acc};
   end
   chk_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus stall or error");
   chk_rdata_width: assert property (HRDATA[31:8] == 24'h0)
      else $error("rdata upper bits set");
   chk_field_start: assert property (CA_NO_FIELD && !FIELD_ON |-> ##[1:2] FIELD_ON)
      else $error("own field not on");
   chk_field_cause: assert property ($rose(FIELD_ON) |->
      $past(CA_NO_FIELD) || $past(CA_NO_FIELD, 2))
      else $error("field on without cause");
   chk_field_hold: assert property (FIELD_ON && !FIELD_OFF_REQ |=> FIELD_ON)
      else $error("field dropped");
   chk_field_drop: assert property ($fell(FIELD_ON) |-> $past(FIELD_OFF_REQ))
      else $error("field off without request");
   chk_irq_fall: assert property ($fell(IRQ) |-> |acc_q)
      else $error("irq fell without access");
   chk_rdata_hold: assert property (!$stable(HRDATA) |-> $past(acc && !HWRITE))
      else $error("rdata moved without read");
   chk_reset_quiet: assert property ($rose(RST_N) |-> !IRQ && !FIELD_ON)
      else $error("irq or field after reset");
endmodule
bind nfc_irq_flags_and_masks nfc_irq_chk chk_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CA_NO_FIELD(CA_NO_FIELD),
   .FIELD_OFF_REQ(FIELD_OFF_REQ), .FIELD_ON(FIELD_ON), .IRQ(IRQ));
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [15:0] ev = 16'h0;
   logic [9:0] cnt = 10'h0;
   logic oen = 1'h0, ost = 1'h0, fld = 1'h0, rxa = 1'h0, txa = 1'h0, tm = 1'h1;
   logic foff = 1'h0;
   logic [2:0] mdone = 3'h0;
   logic [23:0] mdelta = 24'h0, mref = 24'h0;
   logic [7:0] tev = 8'h0;
   wire [31:0] hrdata, haddr, hwdata;
   wire [1:0] htrans;
   wire [2:0] hsize;
   wire hsel, hwrite, hready, hresp, field_on, irq;
   int err_total = 0, checked = 0, seed = 55426, k, b;
   // model: 0 main, 1 timer/field, 2 error/wake-up, 3 target
   int mmask[4], mflag[4];
   int wmask[4] = '{32'hfe, 32'hff, 32'hff, 32'h7b};
   logic [5:0] g;
   logic [31:0] m, q;
   initial forever #4 clk = ~clk;
   // small guard count keeps the run short
   nfc_irq_flags_and_masks #(.GUARD_CYCLES(4)) nfc_irq_flags_and_masks_i (
      .CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .OSC_EN(oen),
      .OSC_STABLE(ost), .EXT_FIELD(fld), .RX_START(ev[4]), .RX_END(ev[3]),
      .TX_END(ev[2]), .BIT_COLLISION(ev[1]), .DISTURBANCE_FRAME(ev[0]),
      .FIFO_COUNT(cnt), .RX_ACTIVE(rxa), .TX_ACTIVE(txa), .DCT_DONE(ev[9]),
      .NRT_EXPIRE(ev[8]), .GPT_EXPIRE(ev[7]), .CA_COLLISION(ev[6]),
      .CA_NO_FIELD(ev[15]), .FIELD_OFF_REQ(foff), .TARGET_MODE(tm),
      .BITRATE_FOUND(ev[5]), .ERR_EVENTS(ev[14:10]), .MEAS_DONE(mdone),
      .MEAS_DELTA(mdelta), .MEAS_REF(mref), .TGT_EVENTS(tev),
      .FIELD_ON(field_on), .IRQ(irq));
   host_model host_model_i (.clk(clk), .HREADY(hready), .HRDATA(hrdata),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task rd(input logic [5:0] i, input logic [31:0] e, input string n);
      host_model_i.xfer(1'h0, i, 32'h0, q);
      chk(n, q, e);
   endtask
   task wr(input logic [5:0] i, input logic [31:0] d);
      host_model_i.xfer(1'h1, i, d, q);
      if (i >= 6'h16 && i <= 6'h19) mmask[i - 6'h16] = d & wmask[i - 6'h16];
   endtask
   // flag read: expect the model, then the model clears it
   task rdf(input int r, input string n);
      int e;
      e = mflag[r];
      mflag[r] = 0;
      rd(6'h1a + r[5:0], e, n);
   endtask
   task chk_irq(input string n);
      int j, e;
      e = 0;
      for (j = 0; j < 4; j++) if ((mflag[j] & ~mmask[j]) != 0) e = 1;
      chk(n, irq, e);
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task pulse(input int n);
      @(posedge clk);
      ev <= 16'h1 << n;
      @(posedge clk);
      ev <= 16'h0;
   endtask
   task end_sim;
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      end_sim;
   end
   initial begin
      wt(12);
      rst_n <= 1'h1;
      for (k = 22; k < 26; k++) rd(k[5:0], 32'h0, "mask reset");
      rd(6'h3f, 32'h0, "unmapped");
      wr(6'h1a, 32'hff);
      rd(6'h1a, 32'h0, "main read only");
      wr(6'h19, 32'hff);
      rd(6'h19, 32'h7b, "target mask");
      // one event on each of ev[0] to ev[14]: random mask, flag, irq, clear on read
      for (k = 0; k < 15; k++) begin
         g = k < 5 ? 6'h0 : k < 10 ? 6'h1 : 6'h2;
         b = g == 0 ? k + 1 : g == 2 ? k - 7 : k == 5 ? 0 : k == 6 ? 2 : k - 2;
         wr(6'h16 + g, $random(seed));
         rd(6'h16 + g, mmask[g], "mask");
         pulse(k);
         mflag[g] |= 1 << b;
         wt(3);
         chk_irq("irq");
         rdf(g, "flag");
         rd(6'h1a + g, 32'h0, "flag cleared");
         chk_irq("irq cleared");
      end
      tm <= 1'h0;
      pulse(5);
      wt(3);
      rdf(1, "rate outside target");
      rdf(1, "clash cleared");
      pulse(15);
      wt(2);
      chk("field on", field_on, 1'h1);
      // guard flag lands in the clearing edge and must survive it
      rd(6'h1b, 32'h0, "guard early");
      mflag[1] |= 32'h2;
      wt(8);
      rdf(1, "guard done");
      @(posedge clk);
      foff <= 1'h1;
      @(posedge clk);
      foff <= 1'h0;
      wt(2);
      chk("field off", field_on, 1'h0);
      fld <= 1'h1;
      wt(8);
      mflag[1] |= 32'h10;
      rdf(1, "field up");
      fld <= 1'h0;
      wt(8);
      mflag[1] |= 32'h8;
      rdf(1, "field down");
      ost <= 1'h1;
      wt(8);
      rdf(0, "osc not enabled");
      ost <= 1'h0;
      oen <= 1'h1;
      wt(4);
      ost <= 1'h1;
      wt(8);
      mflag[0] |= 32'h80;
      rdf(0, "osc stable");
      for (k = 0; k < 2; k++) begin
         rxa <= k == 0;
         txa <= k == 1;
         cnt <= k ? 10'h0c8 : 10'h12c;
         wt(4);
         rdf(0, "fifo at limit");
         cnt <= k ? 10'h0c7 : 10'h12d;
         wt(4);
         mflag[0] |= 32'h40;
         rdf(0, "fifo past limit");
      end
      // quiet levels so no event fires after the later reset
      rxa <= 1'h0;
      txa <= 1'h0;
      oen <= 1'h0;
      ost <= 1'h0;
      for (k = 0; k < 3; k++) begin
         mref <= 24'h404040;
         mdelta <= 24'h404040;
         mdone <= 3'h1 << k;
         @(posedge clk);
         mdone <= 3'h0;
         wt(3);
         rdf(2, "wake equal");
         mdelta <= 24'h414141;
         mdone <= 3'h1 << k;
         @(posedge clk);
         mdone <= 3'h0;
         mflag[2] |= 1 << k;
         wt(3);
         chk_irq("wake irq");
         rdf(2, "wake above");
      end
      wr(6'h19, $random(seed));
      rd(6'h19, mmask[3], "target mask random");
      @(posedge clk);
      tev <= 8'hff;
      @(posedge clk);
      tev <= 8'h0;
      mflag[3] |= 32'h7b;
      wt(3);
      chk_irq("target irq");
      rdf(3, "target flags");
      // reset in mid-run with masks written and a flag pending
      pulse(9);
      @(posedge clk);
      rst_n <= 1'h0;
      wt(2);
      rst_n <= 1'h1;
      for (k = 0; k < 4; k++) begin
         mmask[k] = 0;
         mflag[k] = 0;
      end
      for (k = 22; k < 30; k++) rd(k[5:0], 32'h0, "reset again");
      chk_irq("irq after reset");
      end_sim;
   end
endmodule
`default_nettype wire
